//--- core/mos_defines.svh
// Constants for the optional status monitor
// Functional notes
// - DTMF mode: sixteen tone cell outputs fill bytes 0 and 1, cell 0 at bit 0.
// - DTMF mode: detected digit sits in byte 2, valid when the detect flag rises.
// - Digit value is held until a new digit is detected.
// - Modem mode: byte 0 bit 0 is speed valid; bits 4..1 carry the speed.
// - Speed fields only for V.33 receive; valid rises with the scrambled ones flag.
// - Speed code 1000 means 14400 bit/s, 0111 means 12000 bit/s.
// - Modem mode: byte 2 holds one training progress flag per bit.
// - Bit 0 is set while the echo protection carrier is transmitted.
// - Bit 1 is set while the phase reversal segment is received.
// - Bit 3 marks the transmitted rate segment; bit 2 marks equalizer training.
// - Bit 4 marks the scrambled ones segment in either direction.
// - Bit 5 turns on once receive equalizer training is detected.
// - Bit 6 turns on once the rate segment is detected in V.33 or V.17.
// - Bit 7 turns on after the receive equalizer trains successfully.
// - Start of transmit synchronization clears progress flags 5 to 7 and speed valid.
// - V.29 and V.27 keep both rate segment flags inactive.
// - Clear to send rises after scrambled ones, falls when turn-off starts.
`ifndef MOS_DEFINES_SVH
`define MOS_DEFINES_SVH
`define MOS_ADDR_W        6
`define MOS_ADDR_BYTE0    6'h0C
`define MOS_ADDR_BYTE1    6'h0D
`define MOS_ADDR_BYTE2    6'h0E
`define MOS_SPEED_14400   4'h8
`define MOS_SPEED_12000   4'h7
`define MOS_BIT_ECHO      0
`define MOS_BIT_REVERSAL  1
`define MOS_BIT_EQ_TRAIN  2
`define MOS_BIT_RATE_TX   3
`define MOS_BIT_SCR1      4
`define MOS_BIT_EQ_SEEN   5
`define MOS_BIT_RATE_SEEN 6
`define MOS_BIT_EQ_DONE   7
`define MOS_ZERO_BYTE     8'h00
`define MOS_ZERO_NIBBLE   4'h0
`define MOS_ZERO_CELLS    16'h0000
`endif

//--- core/mos_pkg.sv
// Types for the optional status monitor
package mos_pkg;
  typedef enum logic [1:0] {MOS_TONE, MOS_DTMF, MOS_MODEM} mos_mode_e;
  typedef enum logic [1:0] {MOS_V17, MOS_V33, MOS_V29, MOS_V27} mos_std_e;
  typedef enum logic [2:0] {
    TX_IDLE, TX_ECHO, TX_REVERSAL, TX_EQ_TRAIN, TX_RATE, TX_SCR1, TX_DATA
  } mos_tx_e;
  typedef struct packed {
    mos_tx_e     tx_state;
    logic        cts;
    logic        rx_scr1_last;
    logic        eq_seen;
    logic        rate_seen;
    logic        eq_done;
    logic        speed_valid;
    logic [3:0]  speed;
    logic [3:0]  digit;
    logic [15:0] cells;
    logic [7:0]  rdata;
  } mos_state_s;
endpackage : mos_pkg

//--- core/mos_monitor.sv
// Optional status bytes and training progress tracking of the data pump
`timescale 1ns/1ns
`default_nettype none
`include "mos_defines.svh"
module mos_monitor (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // Operating mode
  input  wire mos_pkg::mos_mode_e    mode,
  input  wire mos_pkg::mos_std_e     std_sel,
  input  wire logic                  echo_protect_en,
  input  wire logic                  baud_tick,
  // Tone detector and keypad detector
  input  wire logic [15:0]           tone_cell_output,
  input  wire logic                  keypad_digit_detected,
  input  wire logic [3:0]            keypad_digit_in,
  // Transmit sequencing
  input  wire logic                  start_tx_sync_command,
  input  wire logic                  tx_segment_done,
  input  wire logic                  tx_turnoff_start,
  // Receive detectors
  input  wire logic                  rx_active,
  input  wire logic                  rx_reversal,
  input  wire logic                  rx_eq_training,
  input  wire logic                  rx_scr1,
  input  wire logic                  rx_eq_seen,
  input  wire logic                  rx_rate_seen,
  input  wire logic                  rx_eq_trained,
  input  wire logic [3:0]            rx_speed_code,
  // Host read port of the shared RAM
  input  wire logic                  host_rd,
  input  wire logic [`MOS_ADDR_W-1:0] host_addr,
  output logic [7:0]                 host_rdata,
  // Status toward the general status word
  output logic                       clear_to_send_status,
  output logic                       tx_sync_in_progress,
  output logic [7:0]                 monitor_byte_0,
  output logic [7:0]                 monitor_byte_1,
  output logic [7:0]                 monitor_byte_2
);

  mos_pkg::mos_state_s state_reg;
  mos_pkg::mos_state_s state_next;

  logic       is_rate_std;
  logic       tx_on;
  logic       rx_on;
  logic [7:0] progress;
  logic [7:0] byte0;
  logic [7:0] byte1;
  logic [7:0] byte2;

  // Rate segment exists only in V.33 and V.17
  assign is_rate_std = (std_sel == mos_pkg::MOS_V33) ||
                       (std_sel == mos_pkg::MOS_V17);
  assign tx_on = (state_reg.tx_state != mos_pkg::TX_IDLE) &&
                 (state_reg.tx_state != mos_pkg::TX_DATA);
  assign rx_on = rx_active && (mode == mos_pkg::MOS_MODEM);

  // Progress flags, bits 0 to 4 live only in their own segment, bits 5 to 7 sticky
  always_comb begin
    progress = `MOS_ZERO_BYTE;
    progress[`MOS_BIT_ECHO]      = state_reg.tx_state == mos_pkg::TX_ECHO;
    progress[`MOS_BIT_REVERSAL]  = rx_on && rx_reversal;
    progress[`MOS_BIT_EQ_TRAIN]  = (state_reg.tx_state == mos_pkg::TX_EQ_TRAIN) ||
                                   (rx_on && rx_eq_training);
    progress[`MOS_BIT_RATE_TX]   = state_reg.tx_state == mos_pkg::TX_RATE;
    // Receive side registered so it rises together with speed valid
    progress[`MOS_BIT_SCR1]      = (state_reg.tx_state == mos_pkg::TX_SCR1) ||
                                   state_reg.rx_scr1_last;
    progress[`MOS_BIT_EQ_SEEN]   = state_reg.eq_seen;
    progress[`MOS_BIT_RATE_SEEN] = state_reg.rate_seen;
    progress[`MOS_BIT_EQ_DONE]   = state_reg.eq_done;
  end

  // Byte layouts per mode
  always_comb begin
    byte0 = `MOS_ZERO_BYTE;
    byte1 = `MOS_ZERO_BYTE;
    byte2 = `MOS_ZERO_BYTE;
    unique case (mode)
      mos_pkg::MOS_DTMF: begin
        byte0 = state_reg.cells[7:0];
        byte1 = state_reg.cells[15:8];
        byte2 = {`MOS_ZERO_NIBBLE, state_reg.digit};
      end
      mos_pkg::MOS_MODEM: begin
        // Upper three bits and byte 1 read as zero
        byte0 = {3'h0, state_reg.speed, state_reg.speed_valid};
        byte2 = progress;
      end
      default: begin
        byte0 = `MOS_ZERO_BYTE;
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;
    state_next.rx_scr1_last = rx_on && rx_scr1;

    // Tone cells sampled once per baud
    if (baud_tick) begin
      state_next.cells = tone_cell_output;
    end

    // Digit kept until the next detection
    if (mode == mos_pkg::MOS_DTMF && keypad_digit_detected) begin
      state_next.digit = keypad_digit_in;
    end

    // Transmit training sequencer
    unique case (state_reg.tx_state)
      mos_pkg::TX_IDLE: begin
        state_next.tx_state = mos_pkg::TX_IDLE;
      end
      mos_pkg::TX_ECHO: begin
        if (tx_segment_done) begin
          state_next.tx_state = mos_pkg::TX_REVERSAL;
        end
      end
      mos_pkg::TX_REVERSAL: begin
        if (tx_segment_done) begin
          state_next.tx_state = mos_pkg::TX_EQ_TRAIN;
        end
      end
      mos_pkg::TX_EQ_TRAIN: begin
        if (tx_segment_done) begin
          state_next.tx_state = is_rate_std ? mos_pkg::TX_RATE
                                            : mos_pkg::TX_SCR1;
        end
      end
      mos_pkg::TX_RATE: begin
        if (tx_segment_done) begin
          state_next.tx_state = mos_pkg::TX_SCR1;
        end
      end
      mos_pkg::TX_SCR1: begin
        if (tx_segment_done) begin
          state_next.tx_state = mos_pkg::TX_DATA;
          state_next.cts      = 1'b1;
        end
      end
      mos_pkg::TX_DATA: begin
        if (tx_turnoff_start) begin
          state_next.tx_state = mos_pkg::TX_IDLE;
          state_next.cts      = 1'b0;
        end
      end
      default: begin
        state_next.tx_state = mos_pkg::TX_IDLE;
      end
    endcase

    // Receive progress, sticky until the next transmit start
    if (rx_on && rx_eq_seen) begin
      state_next.eq_seen = 1'b1;
    end
    if (rx_on && rx_rate_seen && is_rate_std) begin
      state_next.rate_seen = 1'b1;
    end
    if (rx_on && rx_eq_trained) begin
      state_next.eq_done = 1'b1;
    end

    // Speed latched on the rising scrambled ones edge in V.33
    if (rx_on && std_sel == mos_pkg::MOS_V33 && rx_scr1 && !state_reg.rx_scr1_last &&
        (rx_speed_code == `MOS_SPEED_14400 || rx_speed_code == `MOS_SPEED_12000)) begin
      state_next.speed       = rx_speed_code;
      state_next.speed_valid = 1'b1;
    end

    // Start of transmit sync clears the sticky progress flags and the speed
    if (start_tx_sync_command) begin
      state_next.tx_state    = echo_protect_en ? mos_pkg::TX_ECHO
                                               : mos_pkg::TX_REVERSAL;
      state_next.cts         = 1'b0;
      state_next.eq_seen     = 1'b0;
      state_next.rate_seen   = 1'b0;
      state_next.eq_done     = 1'b0;
      state_next.speed_valid = 1'b0;
      state_next.speed       = `MOS_ZERO_NIBBLE;
    end

    // Host read, one cycle latency
    if (host_rd) begin
      unique case (host_addr)
        `MOS_ADDR_BYTE0: state_next.rdata = byte0;
        `MOS_ADDR_BYTE1: state_next.rdata = byte1;
        `MOS_ADDR_BYTE2: state_next.rdata = byte2;
        default:         state_next.rdata = `MOS_ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg.tx_state     <= mos_pkg::TX_IDLE;
      state_reg.cts          <= 1'b0;
      state_reg.rx_scr1_last <= 1'b0;
      state_reg.eq_seen      <= 1'b0;
      state_reg.rate_seen    <= 1'b0;
      state_reg.eq_done      <= 1'b0;
      state_reg.speed_valid  <= 1'b0;
      state_reg.speed        <= `MOS_ZERO_NIBBLE;
      state_reg.digit        <= `MOS_ZERO_NIBBLE;
      state_reg.cells        <= `MOS_ZERO_CELLS;
      state_reg.rdata        <= `MOS_ZERO_BYTE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign host_rdata           = state_reg.rdata;
  assign clear_to_send_status = state_reg.cts;
  assign tx_sync_in_progress  = tx_on;
  assign monitor_byte_0       = byte0;
  assign monitor_byte_1       = byte1;
  assign monitor_byte_2       = byte2;

endmodule : mos_monitor
`default_nettype wire

//--- verif/mos_monitor_props.sv
// Concurrent checks on the status monitor ports
`timescale 1ns/1ns
`default_nettype none
module mos_monitor_props (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               rst_n,
  // Inputs watched
  input wire mos_pkg::mos_mode_e mode,
  input wire mos_pkg::mos_std_e  std_sel,
  input wire logic               baud_tick,
  input wire logic [15:0]        tone_cell_output,
  input wire logic               keypad_digit_detected,
  input wire logic [3:0]         keypad_digit_in,
  input wire logic               start_tx_sync_command,
  input wire logic               tx_turnoff_start,
  input wire logic               rx_active,
  input wire logic               rx_scr1,
  input wire logic [3:0]         rx_speed_code,
  input wire logic               host_rd,
  input wire logic [5:0]         host_addr,
  // Outputs watched
  input wire logic [7:0]         host_rdata,
  input wire logic               clear_to_send_status,
  input wire logic               tx_sync_in_progress,
  input wire logic [7:0]         monitor_byte_0,
  input wire logic [7:0]         monitor_byte_1,
  input wire logic [7:0]         monitor_byte_2
);
  wire logic dt = mode == mos_pkg::MOS_DTMF;
  wire logic md = mode == mos_pkg::MOS_MODEM;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_cells; dt && baud_tick ##1 dt |-> {monitor_byte_1, monitor_byte_0} == $past(tone_cell_output); endproperty
  a_cells: assert property (p_cells) else $error("cells wrong");
  property p_dig; dt && keypad_digit_detected ##1 dt |-> monitor_byte_2[3:0] == $past(keypad_digit_in); endproperty
  a_dig: assert property (p_dig) else $error("digit wrong");
  property p_hold; dt && !keypad_digit_detected ##1 dt |-> $stable(monitor_byte_2); endproperty
  a_hold: assert property (p_hold) else $error("digit moved");
  property p_clr; md && start_tx_sync_command ##1 md |-> monitor_byte_2[7:5] == 3'h0; endproperty
  a_clr: assert property (p_clr) else $error("flags kept");
  property p_rate; start_tx_sync_command ##0 (md && std_sel == mos_pkg::MOS_V29)[*8] |-> monitor_byte_2[6] == 1'b0 && monitor_byte_2[3] == 1'b0; endproperty
  a_rate: assert property (p_rate) else $error("rate flag set");
  property p_cton; $rose(clear_to_send_status) && md |-> $past(monitor_byte_2[4]); endproperty
  a_cton: assert property (p_cton) else $error("cts early");
  property p_ctoff; clear_to_send_status && tx_turnoff_start |=> !clear_to_send_status; endproperty
  a_ctoff: assert property (p_ctoff) else $error("cts stuck");
  property p_spd; md && std_sel == mos_pkg::MOS_V33 && rx_active && $rose(rx_scr1) && !start_tx_sync_command && rx_speed_code inside {4'h7, 4'h8} ##1 md |-> monitor_byte_0[4:0] == {$past(rx_speed_code), 1'b1}; endproperty
  a_spd: assert property (p_spd) else $error("speed wrong");
  property p_spdsync; md && $past(md) && !$past(tx_sync_in_progress) && $rose(monitor_byte_0[0]) |-> $rose(monitor_byte_2[4]); endproperty
  a_spdsync: assert property (p_spdsync) else $error("speed valid apart from scrambled ones");
  property p_unused; md |-> monitor_byte_1 == 8'h00; endproperty
  a_unused: assert property (p_unused) else $error("byte1 used");
  property p_rd; host_rd && host_addr == 6'h0C |=> host_rdata == $past(monitor_byte_0); endproperty
  a_rd: assert property (p_rd) else $error("read wrong");
endmodule : mos_monitor_props
`default_nettype wire

//--- verif/mos_host_model.sv
// Host processor model reading the shared RAM
`timescale 1ns/1ns
`default_nettype none
module mos_host_model (
  // Read port
  input wire logic       mclk,
  output logic           host_rd,
  output logic [5:0]     host_addr,
  input wire logic [7:0] host_rdata
);
  initial begin
    host_rd = 1'b0;
    host_addr = 6'h3F;
  end
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge mclk);
    host_rd = 1'b1;
    host_addr = a;
    @(negedge mclk);
    d = host_rdata;
    host_rd = 1'b0;
    host_addr = ~a;
  endtask : rd
endmodule : mos_host_model
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the status monitor
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic mclk = 1'b0, rst_n = 1'b0, echo_protect_en = 1'b1, baud_tick = 1'b0;
  mos_pkg::mos_mode_e mode = mos_pkg::MOS_DTMF;
  mos_pkg::mos_std_e std_sel = mos_pkg::MOS_V17;
  logic keypad_digit_detected = 1'b0, start_tx_sync_command = 1'b0, tx_segment_done = 1'b0;
  logic tx_turnoff_start = 1'b0, rx_active = 1'b1, rx_reversal = 1'b0, rx_eq_training = 1'b0;
  logic rx_scr1 = 1'b0, rx_eq_seen = 1'b0, rx_rate_seen = 1'b0, rx_eq_trained = 1'b0;
  logic [15:0] tone_cell_output = 16'h0000;
  logic [3:0] keypad_digit_in = 4'h0, rx_speed_code = 4'h8;
  logic host_rd, clear_to_send_status, tx_sync_in_progress;
  logic [5:0] host_addr;
  logic [7:0] host_rdata, monitor_byte_0, monitor_byte_1, monitor_byte_2, d;
  logic [31:0] seed = 32'h0000007C, c;
  int bad_count = 0, num_checks = 0, cyc = 0;
  mos_monitor uut (.mclk, .rst_n, .mode, .std_sel, .echo_protect_en, .baud_tick,
    .tone_cell_output, .keypad_digit_detected, .keypad_digit_in, .start_tx_sync_command,
    .tx_segment_done, .tx_turnoff_start, .rx_active, .rx_reversal, .rx_eq_training, .rx_scr1,
    .rx_eq_seen, .rx_rate_seen, .rx_eq_trained, .rx_speed_code, .host_rd, .host_addr,
    .host_rdata, .clear_to_send_status, .tx_sync_in_progress, .monitor_byte_0,
    .monitor_byte_1, .monitor_byte_2);
  mos_host_model host (.mclk, .host_rd, .host_addr, .host_rdata);
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (++cyc > 3000) begin
    bad_count++;
    conclude();
  end
  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : nxt
  // Progress flag shown in each transmit segment other than the reversal segment, which shows none
  function automatic logic [7:0] seg_flag(int g);
    return (g == 1) ? 8'h00 : 8'h01 << g;
  endfunction : seg_flag
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask : pulse
  task conclude;
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk) rst_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      c = nxt();
      tone_cell_output = c[15:0];
      keypad_digit_in = c[19:16];
      baud_tick = 1'b1;
      pulse(keypad_digit_detected);
      baud_tick = 1'b0;
      tone_cell_output = ~c[15:0];
      keypad_digit_in = ~c[19:16];
      host.rd(6'h0C, d); chk(d, c[7:0]);
      host.rd(6'h0D, d); chk(d, c[15:8]);
      host.rd(6'h0E, d); chk(d, {4'h0, c[19:16]});
    end
    host.rd(6'h0F, d); chk(d, 8'h00);
    mode = mos_pkg::MOS_MODEM;
    for (int s = 0; s < 2; s++) begin
      std_sel = s ? mos_pkg::MOS_V29 : mos_pkg::MOS_V17;
      echo_protect_en = (s == 0);
      pulse(start_tx_sync_command);
      for (int g = s; g < 5; g++) if (s == 0 || g != 3) begin
        chk(monitor_byte_2, seg_flag(g));
        chk({7'h0, tx_sync_in_progress}, 8'h01);
        pulse(tx_segment_done);
      end
      chk({6'h0, clear_to_send_status, tx_sync_in_progress}, 8'h02);
      repeat (8) @(negedge mclk);
      pulse(tx_turnoff_start);
      chk({7'h0, clear_to_send_status}, 8'h00);
    end
    std_sel = mos_pkg::MOS_V33;
    for (int s = 0; s < 2; s++) begin
      rx_speed_code = s ? 4'h7 : 4'h8;
      rx_reversal = 1'b1;
      rx_eq_training = 1'b1;
      rx_scr1 = 1'b1;
      @(negedge mclk);
      chk(monitor_byte_0, {3'h0, rx_speed_code, 1'b1});
      rx_eq_seen = 1'b1;
      rx_rate_seen = 1'b1;
      pulse(rx_eq_trained);
      chk(monitor_byte_2, 8'hF6);
      chk(monitor_byte_1, 8'h00);
      {rx_eq_seen, rx_rate_seen, rx_scr1, rx_reversal, rx_eq_training} = 5'h00;
      pulse(start_tx_sync_command);
      chk(monitor_byte_2, 8'h00);
    end
    conclude();
  end
endmodule : testbench
bind mos_monitor mos_monitor_props chk_i (.mclk, .rst_n, .mode, .std_sel, .baud_tick,
  .tone_cell_output, .keypad_digit_detected, .keypad_digit_in, .start_tx_sync_command,
  .tx_turnoff_start, .rx_active, .rx_scr1, .rx_speed_code, .host_rd, .host_addr,
  .host_rdata, .clear_to_send_status, .tx_sync_in_progress, .monitor_byte_0, .monitor_byte_1,
  .monitor_byte_2);
`default_nettype wire
